// ==== verilog/adc_out_pkg.sv ====
// Shared constants, types and helpers for the converter output logic.
// Assumes one sample clock; strap levels arrive as comparator codes.
package adc_out_pkg;
  // ----------------------------------------
  // Widths and timing
  // ----------------------------------------
  localparam int DATA_W = 14;
  localparam int PIPE_LATENCY = 7;
  localparam int CLK_PERIOD_NS = 10;
  localparam int DCS_RELOCK_CYCLES = 100;
  localparam int WAKE_CNT_W = 24;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] LAST_OFF = 8'h08;
  localparam logic [7:0] WAKE_OFF = 8'h0C;
  localparam logic [31:0] CTRL_RST = 32'h0000_0001;
  localparam int CTRL_OUT_EN_BIT = 0;
  localparam int CTRL_RELOCK_BIT = 1;
  localparam int STAT_TWOS_BIT = 2;
  localparam int STAT_DCS_ON_BIT = 3;
  localparam int STAT_LOCKED_BIT = 4;
  localparam int STAT_STANDBY_BIT = 5;
  localparam int LAST_OVR_BIT = 14;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {LVL_GND = 2'b00, LVL_THIRD = 2'b01, LVL_TWO_THIRDS = 2'b10,
    LVL_SUPPLY = 2'b11} level_t;
  typedef enum logic [1:0] {REF_DIVIDER = 2'b00, REF_PROG = 2'b01, REF_FIXED = 2'b10,
    REF_EXT = 2'b11} ref_mode_t;
  typedef enum logic [1:0] {DCS_OFF = 2'b00, DCS_ACQ = 2'b01, DCS_LOCKED = 2'b10} dcs_state_t;
  // Offset binary core result to selected format
  function automatic logic [DATA_W-1:0] to_format(input logic [DATA_W-1:0] w, input logic twos);
    to_format = {w[DATA_W-1] ^ twos, w[DATA_W-2:0]};
  endfunction : to_format
endpackage : adc_out_pkg

// ==== verilog/adc_core_if.sv ====
// Signals shared between the output top and its pipeline and strap blocks.
// Assumes all users run on pclk.
`timescale 1ns/100ps
`default_nettype none
interface adc_core_if;
  import adc_out_pkg::*;
  logic [DATA_W-1:0] in_word;
  logic in_ovr;
  logic [DATA_W-1:0] out_word;
  logic out_ovr;
  logic twos_comp;
  logic dcs_on;
  ref_mode_t ref_sel;
  logic standby;
  modport pipe_mp (input in_word, input in_ovr, output out_word, output out_ovr);
  modport strap_mp (output twos_comp, output dcs_on, output ref_sel, output standby);
  modport top_mp (output in_word, output in_ovr, input out_word, input out_ovr,
    input twos_comp, input dcs_on, input ref_sel, input standby);
endinterface : adc_core_if
`default_nettype wire

// ==== verilog/sample_pipe.sv ====
// Fixed-latency delay line for sample words and their range flag.
// Assumes input words come from logic on pclk.
`timescale 1ns/100ps
`default_nettype none
module sample_pipe
  import adc_out_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Samples
  adc_core_if.pipe_mp cif
);
  logic [DATA_W:0] stage_r [PIPE_LATENCY];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < PIPE_LATENCY; i++) begin
        stage_r[i] <= '0;
      end
    end else begin
      stage_r[0] <= {cif.in_ovr, cif.in_word};
      for (int i = 1; i < PIPE_LATENCY; i++) begin
        stage_r[i] <= stage_r[i-1];
      end
    end
  end

  assign cif.out_word = stage_r[PIPE_LATENCY-1][DATA_W-1:0];
  assign cif.out_ovr = stage_r[PIPE_LATENCY-1][DATA_W];

  property p_pipe_delay;
    @(posedge pclk) disable iff (!presetn)
      $past(presetn, 7) |-> ({cif.out_ovr, cif.out_word} == $past({cif.in_ovr, cif.in_word}, 7));
  endproperty
  a_pipe_delay: assert property (p_pipe_delay) else $error("pipeline delay wrong");
endmodule : sample_pipe
`default_nettype wire

// ==== verilog/strap_decode.sv ====
// Synchronises and decodes the mode, sense and power-down straps.
// Assumes straps are static levels from outside the clock domain.
`timescale 1ns/100ps
`default_nettype none
module strap_decode
  import adc_out_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Strap pins
  input wire logic [1:0] mode_level,
  input wire logic [1:0] sense_level,
  input wire logic power_down_input,
  // Decoded
  adc_core_if.strap_mp cif
);
  logic [4:0] s1_r, s2_r, s3_r, agreed_r;
  logic [1:0] mode_q;
  logic [1:0] sense_q;

  // Three-stage synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= {power_down_input, sense_level, mode_level};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Accept a bit once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      agreed_r <= '0;
    end else begin
      for (int i = 0; i < 5; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          agreed_r[i] <= s3_r[i];
        end
      end
    end
  end

  assign mode_q = agreed_r[1:0];
  assign sense_q = agreed_r[3:2];

  // Format, stabiliser and reference decode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cif.twos_comp <= 1'b0;
      cif.dcs_on <= 1'b0;
      cif.ref_sel <= REF_DIVIDER;
      cif.standby <= 1'b0;
    end else begin
      cif.twos_comp <= (mode_q == LVL_SUPPLY) || (mode_q == LVL_TWO_THIRDS);
      cif.dcs_on <= (mode_q == LVL_TWO_THIRDS) || (mode_q == LVL_THIRD);
      cif.ref_sel <= ref_mode_t'(sense_q);
      cif.standby <= agreed_r[4];
    end
  end

  property p_mode_decode;
    @(posedge pclk) disable iff (!presetn)
      $past(presetn) |-> (cif.dcs_on == ($past(mode_q) inside {LVL_THIRD, LVL_TWO_THIRDS}))
        && (cif.twos_comp == $past(mode_q[1]));
  endproperty
  a_mode_decode: assert property (p_mode_decode) else $error("mode decode wrong");
endmodule : strap_decode
`default_nettype wire

// ==== verilog/adc_out_top.sv ====
// Digital side of a 14-bit pipelined converter: output word, format, standby,
// stabiliser lock tracking, reference decode and an APB status port.
// Assumes pclk is the sample clock and the core result arrives on pclk.
//
// Behaviour
// - Each sample appears on the output bus eight cycles after being taken.
// - Output word is refreshed from a flop after every rising edge.
// - Output word is 14 bits, one driver per bit, in chosen format.
// - Power-down high enters standby, disabling reference, buffer and bias.
// - In standby every data output driver is released to high impedance.
// - Power-down low returns the device to normal conversion.
// - Stabiliser regenerates the non-sampling edge and tracks its lock.
// - Output is offset binary or twos complement per mode strap.
// - Sense at supply selects external, at reference pin fixed 0.5 V.
// - Sense near ground selects divider, mid range selects programmable mode.
// - Samples are taken on the rising clock edge.
// - Mode strap selects format and stabiliser state per four levels.
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module adc_out_top
  import adc_out_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Converter core result
  input wire logic [DATA_W-1:0] core_data,
  input wire logic core_overrange,
  // Strap pins
  input wire logic [1:0] mode_level,
  input wire logic [1:0] sense_level,
  input wire logic power_down_input,
  // Output drivers
  output logic [DATA_W-1:0] data_o,
  output logic [DATA_W-1:0] data_oe,
  output logic overrange_flag_o,
  output logic overrange_flag_oe,
  // Analog control
  output logic ref_en,
  output logic bias_en,
  output logic [1:0] ref_sel,
  output logic duty_cycle_stabilizer
);
  adc_core_if cif ();

  logic out_en_r;
  logic relock_r;
  logic [DATA_W-1:0] data_r;
  logic [DATA_W-1:0] data_oe_r;
  logic ovr_r;
  logic ovr_oe_r;
  logic ref_en_r;
  logic bias_en_r;
  logic [1:0] ref_sel_r;
  logic dcs_active_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic [DATA_W:0] last_r;
  logic [WAKE_CNT_W-1:0] wake_cnt_r;
  logic standby_d_r;
  logic dcs_on_d_r;
  dcs_state_t dcs_state_r, dcs_state_nxt;
  logic [6:0] lock_cnt_r;
  logic setup_ph;
  logic wr_acc;
  logic drive_en;

  // ----------------------------------------
  // Sub-blocks
  // ----------------------------------------
  assign cif.in_word = core_data;
  assign cif.in_ovr = core_overrange;

  sample_pipe u_pipe (
    .pclk (pclk),
    .presetn (presetn),
    .cif (cif.pipe_mp)
  );

  strap_decode u_strap (
    .pclk (pclk),
    .presetn (presetn),
    .mode_level (mode_level),
    .sense_level (sense_level),
    .power_down_input (power_down_input),
    .cif (cif.strap_mp)
  );

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  assign setup_ph = psel && !penable;
  assign wr_acc = psel && penable && pready_r && pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= 1'b1;
    end
  end

  // Read data and error are latched in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (setup_ph) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
      case (paddr)
        CTRL_OFF: begin
          prdata_r[CTRL_OUT_EN_BIT] <= out_en_r;
        end
        STATUS_OFF: begin
          prdata_r[1:0] <= ref_sel_r;
          prdata_r[STAT_TWOS_BIT] <= cif.twos_comp;
          prdata_r[STAT_DCS_ON_BIT] <= cif.dcs_on;
          prdata_r[STAT_LOCKED_BIT] <= (dcs_state_r == DCS_LOCKED);
          prdata_r[STAT_STANDBY_BIT] <= cif.standby;
        end
        LAST_OFF: begin
          prdata_r[DATA_W:0] <= last_r;
        end
        WAKE_OFF: begin
          prdata_r[WAKE_CNT_W-1:0] <= wake_cnt_r;
        end
        default: begin
          pslverr_r <= 1'b1;
        end
      endcase
    end
  end

  // Control register: output gate and relock request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_en_r <= CTRL_RST[CTRL_OUT_EN_BIT];
      relock_r <= 1'b0;
    end else begin
      relock_r <= 1'b0;
      if (wr_acc && paddr == CTRL_OFF) begin
        out_en_r <= pwdata[CTRL_OUT_EN_BIT];
        relock_r <= pwdata[CTRL_RELOCK_BIT];
      end
    end
  end

  // ----------------------------------------
  // Duty-cycle stabiliser lock tracking
  // ----------------------------------------
  always_comb begin
    dcs_state_nxt = dcs_state_r;
    case (dcs_state_r)
      DCS_OFF: begin
        if (cif.dcs_on && !cif.standby) begin
          dcs_state_nxt = DCS_ACQ;
        end
      end
      DCS_ACQ: begin
        if (!cif.dcs_on || cif.standby) begin
          dcs_state_nxt = DCS_OFF;
        end else if (lock_cnt_r == 7'(DCS_RELOCK_CYCLES - 1)) begin
          dcs_state_nxt = DCS_LOCKED;
        end
      end
      DCS_LOCKED: begin
        if (!cif.dcs_on || cif.standby) begin
          dcs_state_nxt = DCS_OFF;
        end else if (relock_r) begin
          dcs_state_nxt = DCS_ACQ;
        end
      end
      default: begin
        dcs_state_nxt = DCS_OFF;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dcs_state_r <= DCS_OFF;
    end else begin
      dcs_state_r <= dcs_state_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_cnt_r <= '0;
    end else if (dcs_state_r != DCS_ACQ || relock_r) begin
      lock_cnt_r <= '0;
    end else if (lock_cnt_r != 7'(DCS_RELOCK_CYCLES - 1)) begin
      lock_cnt_r <= lock_cnt_r + 7'd1;
    end
  end

  // Non-sampling edge regenerated while stabiliser is selected and not in standby
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dcs_active_r <= 1'b0;
    end else begin
      dcs_active_r <= cif.dcs_on && !cif.standby;
    end
  end

  // ----------------------------------------
  // Standby, reference and wake tracking
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_en_r <= 1'b1;
      bias_en_r <= 1'b1;
      ref_sel_r <= REF_DIVIDER;
    end else begin
      ref_en_r <= !cif.standby && (cif.ref_sel != REF_EXT);
      bias_en_r <= !cif.standby;
      ref_sel_r <= cif.ref_sel;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      standby_d_r <= 1'b0;
      dcs_on_d_r <= 1'b0;
      wake_cnt_r <= '0;
    end else begin
      standby_d_r <= cif.standby;
      dcs_on_d_r <= cif.dcs_on;
      if (cif.standby) begin
        wake_cnt_r <= '0;
      end else if (wake_cnt_r != {WAKE_CNT_W{1'b1}}) begin
        wake_cnt_r <= wake_cnt_r + 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Output word and drivers
  // ----------------------------------------
  assign drive_en = !cif.standby && out_en_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_r <= '0;
      ovr_r <= 1'b0;
      last_r <= '0;
    end else begin
      data_r <= to_format(cif.out_word, cif.twos_comp);
      ovr_r <= cif.out_ovr;
      last_r <= {cif.out_ovr, to_format(cif.out_word, cif.twos_comp)};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_oe_r <= '0;
      ovr_oe_r <= 1'b0;
    end else begin
      data_oe_r <= {DATA_W{drive_en}};
      ovr_oe_r <= drive_en;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign data_o = data_r;
  assign data_oe = data_oe_r;
  assign overrange_flag_o = ovr_r;
  assign overrange_flag_oe = ovr_oe_r;
  assign ref_en = ref_en_r;
  assign bias_en = bias_en_r;
  assign ref_sel = ref_sel_r;
  assign duty_cycle_stabilizer = dcs_active_r;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_latency;
    @(posedge pclk) disable iff (!presetn)
      ($past(presetn, 8) && $stable(cif.twos_comp)) |->
        (data_o == to_format($past(core_data, 8), cif.twos_comp));
  endproperty
  a_latency: assert property (p_latency) else $error("output word latency wrong");

  property p_ovr_align;
    @(posedge pclk) disable iff (!presetn)
      $past(presetn, 8) |-> (overrange_flag_o == $past(core_overrange, 8));
  endproperty
  a_ovr_align: assert property (p_ovr_align) else $error("overrange flag misaligned");

  property p_format;
    @(posedge pclk) disable iff (!presetn)
      $past(presetn) |-> (data_o[DATA_W-1] == ($past(cif.out_word[DATA_W-1]) ^ $past(cif.twos_comp)))
        && (data_o[DATA_W-2:0] == $past(cif.out_word[DATA_W-2:0]));
  endproperty
  a_format: assert property (p_format) else $error("output format wrong");

  property p_hiz_standby;
    @(posedge pclk) disable iff (!presetn)
      cif.standby |=> (data_oe == '0) && !overrange_flag_oe;
  endproperty
  a_hiz_standby: assert property (p_hiz_standby) else $error("drivers active in standby");

  property p_shutdown;
    @(posedge pclk) disable iff (!presetn)
      $rose(cif.standby) |=> !ref_en && !bias_en;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("bias kept on in standby");

  property p_wake;
    @(posedge pclk) disable iff (!presetn)
      ($fell(cif.standby) && out_en_r) |=> bias_en && (data_oe == {DATA_W{1'b1}});
  endproperty
  a_wake: assert property (p_wake) else $error("no return from standby");

  property p_relock;
    @(posedge pclk) disable iff (!presetn)
      (dcs_state_r == DCS_ACQ && lock_cnt_r == 7'd0 && cif.dcs_on && !cif.standby && !relock_r) |->
        (dcs_state_r == DCS_ACQ) [*8];
  endproperty
  a_relock: assert property (p_relock) else $error("stabiliser locked too early");

  property p_ref_decode;
    @(posedge pclk) disable iff (!presetn)
      $past(presetn) |-> (ref_sel == $past(cif.ref_sel))
        && (ref_en == !($past(cif.standby) || $past(cif.ref_sel) == REF_EXT));
  endproperty
  a_ref_decode: assert property (p_ref_decode) else $error("reference decode wrong");
endmodule : adc_out_top
`default_nettype wire

// ==== tb/capture_model.sv ====
// Capture logic model that registers the parallel sample words.
// Assumes the word and driver enables change just after rising pclk.
`timescale 1ns/100ps
`default_nettype none
module capture_model
  import adc_out_pkg::*;
#(
  parameter int WAKE_CYCLES = 32,
  parameter int RELOCK_CYCLES = 100
)
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Output drivers of the device
  input wire logic [DATA_W-1:0] data_o,
  input wire logic [DATA_W-1:0] data_oe,
  input wire logic overrange_flag_o,
  input wire logic overrange_flag_oe,
  // Rate change notice
  input wire logic relock_req,
  // Captured
  output logic [DATA_W-1:0] cap_word,
  output logic cap_ovr,
  output logic cap_valid
);
  // ----------------------------------------
  // Wire levels
  // ----------------------------------------
  logic [DATA_W:0] last_r;
  logic [DATA_W:0] bus_w;
  logic [DATA_W:0] oe_w;
  int wait_r;
  int lock_r;
  // A released line floats: show a level that changes every cycle
  assign oe_w = {overrange_flag_oe, data_oe};
  assign bus_w = (oe_w & {overrange_flag_o, data_o}) | (~oe_w & ~last_r);
  // ----------------------------------------
  // Capture
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_r <= '0;
      cap_word <= '0;
      cap_ovr <= 1'b0;
      cap_valid <= 1'b0;
      wait_r <= WAKE_CYCLES;
      lock_r <= 0;
    end else begin
      last_r <= bus_w;
      cap_word <= bus_w[DATA_W-1:0];
      cap_ovr <= bus_w[DATA_W];
      if (oe_w != '1) begin
        wait_r <= WAKE_CYCLES;
      end else if (wait_r != 0) begin
        wait_r <= wait_r - 1;
      end
      if (relock_req) begin
        lock_r <= RELOCK_CYCLES;
      end else if (lock_r != 0) begin
        lock_r <= lock_r - 1;
      end
      cap_valid <= (oe_w == '1) && (wait_r == 0) && (lock_r == 0) && !relock_req;
    end
  end
endmodule : capture_model
`default_nettype wire

// ==== tb/pipelined_adc_digital_interface_tb.sv ====
// Self-checking bench for the converter output logic.
// Assumes the design files and the capture model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module pipelined_adc_digital_interface_tb;
  import adc_out_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic [DATA_W-1:0] core_data = 14'h0000;
  logic core_overrange = 1'b0;
  logic [1:0] mode_level = 2'b00, sense_level = 2'b00;
  logic power_down_input = 1'b0, relock_req = 1'b0;
  logic [DATA_W-1:0] data_o, data_oe;
  logic overrange_flag_o, overrange_flag_oe, ref_en, bias_en, duty_cycle_stabilizer, cap_valid;
  logic [1:0] ref_sel;
  logic [31:0] rdv, r1;
  logic errv, chk_on = 1'b0, twos_exp = 1'b0;
  logic [14:0] hist[$];
  logic [14:0] exp_w;
  logic [14:0] exp_d = 15'h0000;
  logic [DATA_W-1:0] cap_word;
  logic cap_ovr;
  int failures = 0, samples_checked = 0;
  always #5 pclk = ~pclk;
  adc_out_top adc_out_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .core_data(core_data), .core_overrange(core_overrange),
    .mode_level(mode_level), .sense_level(sense_level), .power_down_input(power_down_input),
    .data_o(data_o), .data_oe(data_oe), .overrange_flag_o(overrange_flag_o),
    .overrange_flag_oe(overrange_flag_oe), .ref_en(ref_en), .bias_en(bias_en),
    .ref_sel(ref_sel), .duty_cycle_stabilizer(duty_cycle_stabilizer));
  capture_model capture_model_i (.pclk(pclk), .presetn(presetn), .data_o(data_o),
    .data_oe(data_oe), .overrange_flag_o(overrange_flag_o), .overrange_flag_oe(overrange_flag_oe),
    .relock_req(relock_req), .cap_word(cap_word), .cap_ovr(cap_ovr), .cap_valid(cap_valid));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    // Back-to-back call: let one edge pass so the release is not overwritten
    if (psel === 1'b1) @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
    if (n >= 50) failures++;
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic tally_and_finish;
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : tally_and_finish
  // Sample stream and latency monitor
  always @(posedge pclk) begin
    core_data <= core_data + 14'h1a3b;
    core_overrange <= core_data[2];
    if (hist.size() == 8) begin
      exp_w = hist.pop_front();
      if (chk_on) begin
        chk(32'(data_o), 32'(twos_exp ? {~exp_w[13], exp_w[12:0]} : exp_w[13:0]));
        chk(32'(overrange_flag_o), 32'(exp_w[14]));
        chk(32'({cap_ovr, cap_word}), 32'(exp_d));
      end
      exp_d <= {exp_w[14], exp_w[13] ^ twos_exp, exp_w[12:0]};
    end
    hist.push_back({core_overrange, core_data});
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    repeat (4) @(posedge pclk);
    chk(32'(data_oe), 32'h0000_0000);
    chk(32'({ref_en, bias_en}), 32'h0000_0003);
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    repeat (12) @(posedge pclk);
    apb(1'b0, CTRL_OFF, 32'h0000_0000);
    chk(rdv, CTRL_RST);
  endtask : t_reset
  task automatic t_standby;
    power_down_input <= 1'b1;
    repeat (10) @(posedge pclk);
    chk(32'({overrange_flag_oe, data_oe}), 32'h0000_0000);
    chk(32'({ref_en, bias_en, cap_valid}), 32'h0000_0000);
    apb(1'b0, STATUS_OFF, 32'h0000_0000);
    chk(32'(rdv[STAT_STANDBY_BIT]), 32'h0000_0001);
    power_down_input <= 1'b0;
    repeat (10) @(posedge pclk);
    chk(32'({overrange_flag_oe, data_oe, bias_en, ref_en}), 32'h0001_ffff);
    chk(32'(cap_valid), 32'h0000_0000);
    apb(1'b0, WAKE_OFF, 32'h0000_0000);
    r1 = rdv;
    repeat (10) @(posedge pclk);
    apb(1'b0, WAKE_OFF, 32'h0000_0000);
    chk(rdv - r1, 32'h0000_000c);
    repeat (30) @(posedge pclk);
    chk(32'(cap_valid), 32'h0000_0001);
  endtask : t_standby
  task automatic t_modes;
    for (int lv = 0; lv < 4; lv++) begin
      chk_on <= 1'b0;
      mode_level <= 2'(lv);
      twos_exp <= lv[1];
      repeat (20) @(posedge pclk);
      chk_on <= 1'b1;
      chk(32'(duty_cycle_stabilizer), 32'(lv[1] ^ lv[0]));
      apb(1'b0, STATUS_OFF, 32'h0000_0000);
      chk(32'(rdv[3:2]), 32'({lv[1] ^ lv[0], lv[1]}));
      apb(1'b0, LAST_OFF, 32'h0000_0000);
      chk(rdv, 32'(exp_d));
      repeat (30) @(posedge pclk);
    end
    chk_on <= 1'b0;
  endtask : t_modes
  task automatic t_ref;
    for (int s = 0; s < 4; s++) begin
      sense_level <= 2'(s);
      repeat (10) @(posedge pclk);
      chk(32'(ref_sel), 32'(s));
      chk(32'(ref_en), 32'(s != 3));
      apb(1'b0, STATUS_OFF, 32'h0000_0000);
      chk(32'(rdv[1:0]), 32'(s));
    end
    sense_level <= 2'b00;
  endtask : t_ref
  task automatic t_relock;
    mode_level <= 2'b10;
    repeat (130) @(posedge pclk);
    apb(1'b0, STATUS_OFF, 32'h0000_0000);
    chk(32'(rdv[STAT_LOCKED_BIT]), 32'h0000_0001);
    apb(1'b1, CTRL_OFF, 32'h0000_0003);
    relock_req <= 1'b1;
    @(posedge pclk);
    relock_req <= 1'b0;
    repeat (40) @(posedge pclk);
    chk(32'(cap_valid), 32'h0000_0000);
    apb(1'b0, STATUS_OFF, 32'h0000_0000);
    chk(32'(rdv[STAT_LOCKED_BIT]), 32'h0000_0000);
    repeat (80) @(posedge pclk);
    apb(1'b0, STATUS_OFF, 32'h0000_0000);
    chk(32'(rdv[STAT_LOCKED_BIT]), 32'h0000_0001);
  endtask : t_relock
  task automatic t_regs;
    apb(1'b1, CTRL_OFF, 32'h0000_0000);
    repeat (5) @(posedge pclk);
    chk(32'(data_oe), 32'h0000_0000);
    apb(1'b0, CTRL_OFF, 32'h0000_0000);
    chk({31'(rdv), errv}, 32'h0000_0000);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk({31'(rdv), errv}, 32'h0000_0001);
    apb(1'b1, CTRL_OFF, 32'h0000_0001);
    repeat (5) @(posedge pclk);
    chk(32'(data_oe), 32'h0000_3fff);
  endtask : t_regs
  // ----------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------
  initial begin
    t_reset();
    t_standby();
    t_modes();
    t_ref();
    t_relock();
    t_regs();
    tally_and_finish();
  end
  initial begin
    #200000;
    failures++;
    tally_and_finish();
  end
endmodule : pipelined_adc_digital_interface_tb
`default_nettype wire
